// File: src/fetx_encoder.sv
/*
 * top of the 100 Mbps transmit line encoder: 4b/5b encoding with delimiter
 * and idle injection, lsb-first serializer, then the serial line coder.
 * assumes the mac presents nibble, enable and error synchronous to clock_i
 * and holds each nibble for five clocks, taken when nibble_take_o pulses.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fetx_consts.svh"
module fetx_encoder (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic [3:0] txd_i,
   input wire logic tx_en_i,
   input wire logic tx_er_i,
   input wire logic scr_bypass_i,
   input wire logic full_mlt3_i,
   output logic nibble_take_o,
   output logic [4:0] code_group_o,
   output logic nrzi_o,
   output logic tx_pos_o,
   output logic tx_neg_o
);
   // 4b/5b data mapping; it yields only data groups, so no undefined group ever stands inside data
   // for a far receiver to flag; the only control group there is halt, sent when tx_er_i is high
   function automatic logic [4:0] enc4b5b(input logic [3:0] n);
      logic [4:0] c;
      c = `FETX_CG_IDLE;
      case (n)
         4'h0: c = 5'h1e;
         4'h1: c = 5'h09;
         4'h2: c = 5'h14;
         4'h3: c = 5'h15;
         4'h4: c = 5'h0a;
         4'h5: c = 5'h0b;
         4'h6: c = 5'h0e;
         4'h7: c = 5'h0f;
         4'h8: c = 5'h12;
         4'h9: c = 5'h13;
         4'ha: c = 5'h16;
         4'hb: c = 5'h17;
         4'hc: c = 5'h1a;
         4'hd: c = 5'h1b;
         4'he: c = 5'h1c;
         default: c = 5'h1d;
      endcase
      return c;
   endfunction

   fetx_pkg::fetx_tx_state_type st_r, st_nxt; // sequencer state
   logic [4:0] cg_r, cg_nxt; // code-group being serialized
   logic [4:0] shift_r, shift_nxt; // serializer shift register
   logic [2:0] bit_r, bit_nxt; // bit index inside code-group
   logic load; // last bit of a group: choose the next group

   assign load = (bit_r == `FETX_BIT_LAST);

   // sequencer: picks one code-group per five clocks
   always_comb begin
      st_nxt = st_r;
      cg_nxt = cg_r;
      if (load) begin
         case (st_r)
            fetx_pkg::ST_IDLE, fetx_pkg::ST_LPI: begin
               if (tx_en_i) begin
                  // first preamble nibble replaced by J, next by K
                  cg_nxt = `FETX_CG_J;
                  st_nxt = fetx_pkg::ST_SEND_K;
               end else if (tx_er_i && txd_i == `FETX_LPI_NIBBLE) begin
                  cg_nxt = `FETX_CG_P;
                  st_nxt = fetx_pkg::ST_LPI;
               end else begin
                  cg_nxt = `FETX_CG_IDLE;
                  st_nxt = fetx_pkg::ST_IDLE;
               end
            end
            fetx_pkg::ST_SEND_K: begin
               // k goes out even if enable dropped, so j is never orphaned
               cg_nxt = `FETX_CG_K;
               st_nxt = fetx_pkg::ST_DATA;
            end
            fetx_pkg::ST_DATA: begin
               if (!tx_en_i) begin
                  cg_nxt = `FETX_CG_T;
                  st_nxt = fetx_pkg::ST_SEND_R;
               end else if (tx_er_i) begin
                  cg_nxt = `FETX_CG_H;
               end else begin
                  cg_nxt = enc4b5b(txd_i);
               end
            end
            fetx_pkg::ST_SEND_R: begin
               cg_nxt = `FETX_CG_R;
               st_nxt = fetx_pkg::ST_IDLE;
            end
            default: begin
               cg_nxt = `FETX_CG_IDLE;
               st_nxt = fetx_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // serializer: lsb first, one bit per 8 ns symbol
   always_comb begin
      bit_nxt = load ? `FETX_BIT_FIRST : bit_r + 3'h1;
      shift_nxt = load ? cg_nxt : {1'b0, shift_r[4:1]};
   end

   // registers only
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_r <= fetx_pkg::ST_IDLE;
         cg_r <= `FETX_CG_IDLE;
         shift_r <= `FETX_CG_IDLE;
         bit_r <= `FETX_BIT_FIRST;
      end else begin
         st_r <= st_nxt;
         cg_r <= cg_nxt;
         shift_r <= shift_nxt;
         bit_r <= bit_nxt;
      end
   end

   assign nibble_take_o = load;
   assign code_group_o = cg_r;

   // scrambler, nrzi and mlt-3 at the 125 Mbps symbol rate
   fetx_line_coder u_line (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .bit_i(shift_r[0]),
      .scr_bypass_i(scr_bypass_i),
      .full_mlt3_i(full_mlt3_i),
      .nrzi_o(nrzi_o),
      .tx_pos_o(tx_pos_o),
      .tx_neg_o(tx_neg_o)
   );
endmodule
`default_nettype wire

// File: src/fetx_consts.svh
/*
 * constants for the 100 Mbps transmit line encoder: code-groups, scrambler taps,
 * serializer bit indices and timing.
 * assumes it is included by bare name from every design file that needs it.
 */
// How it works
// - data nibbles map to fixed 5-bit code-groups
// - idle code-group 11111 between packets
// - first preamble byte becomes J then K
// - later preamble and data nibbles encoded normally
// - tx enable drop appends T then R
// - idle code-groups follow until next frame
// - halt code-group 00100 marks an error
// - lpi sends P, needs error high, enable low
// - undefined or control groups in data invalid
// - closed-loop 11-bit lfsr xors serial stream
// - scrambler can be bypassed by configuration
// - nrzi encoding always applied, no bypass
// - mlt-3 split into two alternating phased streams
// - nibbles become 125 Mbps mlt-3 symbol stream
// - only mlt-3 symbols, no binary output; the code also brings out nrzi_o and code_group_o
// - config 0x0404 selects full mlt-3 both outputs; the code has no config register and selects it with full_mlt3_i
// - sequencing follows standard 100base-tx transmit machine
`ifndef FETX_CONSTS_SVH
`define FETX_CONSTS_SVH

// control code-groups
`define FETX_CG_IDLE 5'h1f
`define FETX_CG_J 5'h18
`define FETX_CG_K 5'h11
`define FETX_CG_T 5'h0d
`define FETX_CG_R 5'h07
`define FETX_CG_H 5'h04
`define FETX_CG_P 5'h00
// lpi nibble on the mac side
`define FETX_LPI_NIBBLE 4'h1
// preamble nibble whose first two copies become j/k
`define FETX_PREAMBLE_NIBBLE 4'h5
// serializer
`define FETX_CG_BITS 5
`define FETX_BIT_LAST 3'h4
`define FETX_BIT_FIRST 3'h0
// scrambler: x^11 + x^9 + 1
`define FETX_LFSR_SEED 11'h7ff
`define FETX_LFSR_TAP_A 10
`define FETX_LFSR_TAP_B 8
// symbol period and clock period in ps
`define FETX_SYMBOL_PS 8000
`define FETX_CLOCK_PS 8000
`define FETX_SYMBOL_CYCLES ((`FETX_SYMBOL_PS + `FETX_CLOCK_PS - 1) / `FETX_CLOCK_PS)

`endif

// File: src/fetx_pkg.sv
/*
 * types shared by the transmit line encoder files.
 * assumes fetx_consts.svh is available; holds types only.
 */
package fetx_pkg;
   // code-group selection state of the transmit sequencer
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SEND_K,
      ST_DATA,
      ST_SEND_T,
      ST_SEND_R,
      ST_LPI
   } fetx_tx_state_type;
   // mlt-3 level position in the zero, plus, zero, minus cycle
   typedef enum logic [1:0] {
      ML_ZERO_A,
      ML_PLUS,
      ML_ZERO_B,
      ML_MINUS
   } fetx_mlt_type;
endpackage

// File: src/fetx_line_coder.sv
/*
 * serial back end: scrambler with bypass, nrzi encoder and mlt-3 splitter.
 * assumes one serial code-group bit per clock at 125 MHz from the encoder.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fetx_consts.svh"
module fetx_line_coder (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic bit_i,
   input wire logic scr_bypass_i,
   input wire logic full_mlt3_i,
   output logic nrzi_o,
   output logic tx_pos_o,
   output logic tx_neg_o
);
   logic [10:0] lfsr_r, lfsr_nxt; // closed-loop scrambler state
   logic nrzi_r, nrzi_nxt; // current nrzi level
   fetx_pkg::fetx_mlt_type mlt_r, mlt_nxt; // mlt-3 position
   logic pos_r, pos_nxt;
   logic neg_r, neg_nxt;
   logic fb; // lfsr feedback bit
   logic scr_bit; // bit after scrambler or bypass

   // next-state logic for the whole serial chain
   always_comb begin
      fb = lfsr_r[`FETX_LFSR_TAP_A] ^ lfsr_r[`FETX_LFSR_TAP_B];
      // the lfsr runs free even in bypass, so toggling bypass keeps sync
      lfsr_nxt = {lfsr_r[9:0], fb};
      scr_bit = scr_bypass_i ? bit_i : (bit_i ^ fb);
      // nrzi has no bypass path at all
      nrzi_nxt = nrzi_r ^ scr_bit;
      // advance mlt-3 only on an nrzi transition
      mlt_nxt = mlt_r;
      if (scr_bit) begin
         case (mlt_r)
            fetx_pkg::ML_ZERO_A: mlt_nxt = fetx_pkg::ML_PLUS;
            fetx_pkg::ML_PLUS: mlt_nxt = fetx_pkg::ML_ZERO_B;
            fetx_pkg::ML_ZERO_B: mlt_nxt = fetx_pkg::ML_MINUS;
            default: mlt_nxt = fetx_pkg::ML_ZERO_A;
         endcase
      end
      // two alternately phased streams, one per driver side
      pos_nxt = (mlt_nxt == fetx_pkg::ML_PLUS);
      // full mode drives the negative side as well; otherwise that side rests
      neg_nxt = (mlt_nxt == fetx_pkg::ML_MINUS) & full_mlt3_i;
   end

   // registers only
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lfsr_r <= `FETX_LFSR_SEED;
         nrzi_r <= 1'b0;
         mlt_r <= fetx_pkg::ML_ZERO_A;
         pos_r <= 1'b0;
         neg_r <= 1'b0;
      end else begin
         lfsr_r <= lfsr_nxt;
         nrzi_r <= nrzi_nxt;
         mlt_r <= mlt_nxt;
         pos_r <= pos_nxt;
         neg_r <= neg_nxt;
      end
   end

   assign nrzi_o = nrzi_r;
   assign tx_pos_o = pos_r;
   assign tx_neg_o = neg_r;
endmodule
`default_nettype wire

// File: sim/fetx_encoder_sva.sv
/* checker for the transmit encoder ports.
   assumes it is bound to fetx_encoder and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module fetx_encoder_chk (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic [3:0] txd_i,
   input wire logic tx_en_i,
   input wire logic tx_er_i,
   input wire logic full_mlt3_i,
   input wire logic nibble_take_o,
   input wire logic [4:0] code_group_o,
   input wire logic nrzi_o,
   input wire logic tx_pos_o,
   input wire logic tx_neg_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   // data code-groups indexed by nibble
   localparam logic [4:0] MAP [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
   wire logic tk = nibble_take_o; // take strobe
   wire logic [4:0] cg = code_group_o; // group on the line
   // k, data or halt last sent: inside a frame
   wire logic fr = !(cg inside {5'h1f, 5'h18, 5'h0d, 5'h07, 5'h00});
   property p_take; tk |=> !tk [*4] ##1 tk; endproperty
   a_take: assert property (p_take) else $error("take spacing wrong");
   property p_jk; tk && tx_en_i && cg == 5'h1f |=> cg == 5'h18 ##5 cg == 5'h11; endproperty
   a_jk: assert property (p_jk) else $error("start pair wrong");
   property p_data; tk && tx_en_i && !tx_er_i && fr |=> cg == MAP[$past(txd_i)]; endproperty
   a_data: assert property (p_data) else $error("data group wrong");
   property p_end; tk && !tx_en_i && fr |=> cg == 5'h0d ##5 cg == 5'h07; endproperty
   a_end: assert property (p_end) else $error("end pair wrong");
   property p_idle; tk && !tx_en_i && !tx_er_i && cg inside {5'h07, 5'h1f} |=> cg == 5'h1f;
   endproperty
   a_idle: assert property (p_idle) else $error("idle missing");
   property p_halt; tk && tx_en_i && tx_er_i && fr |=> cg == 5'h04; endproperty
   a_halt: assert property (p_halt) else $error("halt missing");
   property p_lpi; tk && !tx_en_i && tx_er_i && txd_i == 4'h1 && cg inside {5'h1f, 5'h00}
      |=> cg == 5'h00; endproperty
   a_lpi: assert property (p_lpi) else $error("lpi group missing");
   property p_half; !full_mlt3_i |=> !tx_neg_o; endproperty
   a_half: assert property (p_half) else $error("negative side driven");
   property p_step; $changed(tx_pos_o) |-> $changed(nrzi_o); endproperty
   a_step: assert property (p_step) else $error("mlt step without nrzi edge");
   property p_valid; !(cg inside {5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0c, 5'h10,
      5'h19}); endproperty
   a_valid: assert property (p_valid) else $error("undefined group sent");
endmodule
bind fetx_encoder fetx_encoder_chk u_chk (.clock_i(clock_i), .nrst_i(nrst_i), .txd_i(txd_i),
   .tx_en_i(tx_en_i), .tx_er_i(tx_er_i), .full_mlt3_i(full_mlt3_i),
   .nibble_take_o(nibble_take_o), .code_group_o(code_group_o), .nrzi_o(nrzi_o),
   .tx_pos_o(tx_pos_o), .tx_neg_o(tx_neg_o));
`default_nettype wire

// File: sim/fetx_mac_model.sv
/* mac side model: presents one queued nibble per take.
   assumes the bench fills stim_q and drains exp_q by hierarchy. */
`timescale 1ns/1ps
`default_nettype none
module fetx_mac_model (
   input wire logic clock_i,
   input wire logic take_i,
   output logic [3:0] txd_o,
   output logic tx_en_o,
   output logic tx_er_o
);
   logic [10:0] stim_q[$]; // {en, er, nibble, expected group}
   logic [4:0] exp_q[$]; // groups owed, oldest first
   logic [10:0] cur; // item now on the pins
   initial begin
      {tx_en_o, tx_er_o, txd_o} = 6'h00;
      exp_q.push_back(5'h1f);
   end
   // change pins only just after a take, so each nibble stands five clocks
   always @(posedge clock_i) begin
      if (take_i === 1'b1) begin
         #1;
         cur = (stim_q.size() > 0) ? stim_q.pop_front() : {6'h00, 5'h1f};
         {tx_en_o, tx_er_o, txd_o} = cur[10:5];
         exp_q.push_back(cur[4:0]);
      end
   end
endmodule
`default_nettype wire

// File: sim/testbench.sv
/* self-checking bench: random frames, halt and lpi under all scrambler and drive settings.
   assumes the mac model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clock_i = 1'b0;
   logic nrst_i = 1'b0;
   logic scr_bypass_i = 1'b0;
   logic full_mlt3_i = 1'b0;
   logic [3:0] txd_i;
   logic tx_en_i, tx_er_i, nibble_take_o, nrzi_o, tx_pos_o, tx_neg_o;
   logic [4:0] code_group_o;
   logic [10:0] lfsr; // reference scrambler
   logic nz, b, fb, sb; // reference nrzi and current bit
   logic fm; // drive mode as the design saw it at this edge
   logic [1:0] lvl; // reference mlt-3 position
   int idx, err_count = 0, checks = 0;
   logic [4:0] map [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
   always #4 clock_i = ~clock_i;
   fetx_mac_model u_mac (.clock_i(clock_i), .take_i(nibble_take_o), .txd_o(txd_i),
      .tx_en_o(tx_en_i), .tx_er_o(tx_er_i));
   fetx_encoder u_fetx_encoder (.clock_i(clock_i), .nrst_i(nrst_i), .txd_i(txd_i),
      .tx_en_i(tx_en_i), .tx_er_i(tx_er_i), .scr_bypass_i(scr_bypass_i),
      .full_mlt3_i(full_mlt3_i), .nibble_take_o(nibble_take_o), .code_group_o(code_group_o),
      .nrzi_o(nrzi_o), .tx_pos_o(tx_pos_o), .tx_neg_o(tx_neg_o));
   task automatic check(input string what, input logic [4:0] seen, input logic [4:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic push(input logic [5:0] pins, input logic [4:0] g);
      u_mac.stim_q.push_back({pins, g});
   endtask
   // frame: j/k over the first preamble byte, random data, one halt if asked, t/r, idle
   task automatic frame(input int n, input bit err);
      logic [3:0] d;
      push(6'h25, 5'h18);
      push(6'h25, 5'h11);
      for (int i = 0; i < n; i++) begin
         d = 4'($urandom);
         push({2'b10, d} | {1'b0, err && i == 1, 4'h0}, (err && i == 1) ? 5'h04 : map[d]);
      end
      push(6'h00, 5'h0d);
      push(6'h00, 5'h07);
      push(6'h00, 5'h1f);
   endtask
   // bounded wait until all but the last queued nibble have been encoded and compared
   task automatic drain();
      int t;
      for (t = 0; t < 3000 && u_mac.exp_q.size() + u_mac.stim_q.size() > 1; t++) begin
         @(posedge clock_i);
      end
      if (t == 3000) begin
         err_count++;
         summarize();
      end
   endtask
   // code-group monitor: oldest owed group against what appears at each take
   always @(posedge clock_i) begin
      if (nibble_take_o === 1'b1) begin
         #2 check("code_group", code_group_o, u_mac.exp_q.pop_front());
      end
   end
   // serial reference: lsb first, scramble, nrzi, mlt-3, compared after each edge
   always @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         {lfsr, nz, lvl, idx} = {11'h7ff, 1'b0, 2'h0, 0};
      end else begin
         check("take", nibble_take_o, idx == 4);
         b = code_group_o[idx];
         fb = lfsr[10] ^ lfsr[8];
         sb = scr_bypass_i ? b : b ^ fb;
         lfsr = {lfsr[9:0], fb};
         nz = nz ^ sb;
         lvl = lvl + {1'b0, sb};
         idx = (idx == 4) ? 0 : idx + 1;
         // mode may change just after this edge, so keep the value the design used
         fm = full_mlt3_i;
         #2 check("nrzi", nrzi_o, nz);
         check("tx_pos", tx_pos_o, lvl == 2'h1);
         check("tx_neg", tx_neg_o, lvl == 2'h3 && fm);
      end
   end
   initial begin
      void'($urandom(32'h8c893909));
      repeat (6) @(posedge clock_i);
      #1 nrst_i = 1'b1;
      for (int m = 0; m < 8; m++) begin
         {scr_bypass_i, full_mlt3_i} = 2'(m);
         // lpi first, so the frame start is also taken from the lpi state
         push(6'h11, 5'h00);
         push(6'h11, 5'h00);
         frame($urandom_range(2, 12), m[2]);
         push(6'h00, 5'h1f);
         drain();
         #1;
      end
      summarize();
   end
endmodule
`default_nettype wire
